// ==== logic/xcvr_pkg.sv ====
// shared types, constants and helpers for the dual octal registered transceiver
package xcvr_pkg;
   localparam int HALVES = 2;            // independent octal halves
   localparam int DIRS = 2;              // directions per half
   localparam int PATHS = HALVES * DIRS; // storage paths in total
   localparam int BYTE_W = 8;            // width of one bus side
   localparam int DIR_AB = 0;            // a side to b side
   localparam int DIR_BA = 1;            // b side to a side

   typedef logic [BYTE_W-1:0] byte_t;    // one octal bus word

   // control pins of one direction, carried together
   typedef struct packed {
      logic cp;    // direction_capture_clock
      logic ce_n;  // direction_capture_enable_n
      logic oe_n;  // direction_drive_enable_n
   } ctrl_s;

   localparam byte_t DATA_RST = 8'h00;                          // power-up register contents
   localparam ctrl_s CTRL_IDLE = '{cp: 1'b0, ce_n: 1'b1, oe_n: 1'b1}; // inactive controls

   // path number from half and direction
   function automatic logic [1:0] path_idx(input int half, input int dir);
      path_idx = 2'(half * DIRS + dir);
   endfunction : path_idx
endpackage : xcvr_pkg

// ==== logic/word_buf2.sv ====
// two-entry valid/ready buffer between capture and storage
`timescale 1ns/10ps
module word_buf2 #(
   parameter int W = 8
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // filling side
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [W-1:0] i_in_data,
   // draining side
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [W-1:0] o_out_data
);
   // whole state: two words, a fill count and a ready flag, head in ent0
   typedef struct packed {
      logic [W-1:0] ent0;
      logic [W-1:0] ent1;
      logic [1:0] cnt;
      logic rdy; // a slot is free; kept in a flop so the ready pin leaves a register
   } buf_s;

   // empty after reset, so the filling side may push at once
   localparam buf_s BUF_RST = '{ent0: '0, ent1: '0, cnt: 2'd0, rdy: 1'b1};

   buf_s st_reg; // registered state
   buf_s st_next; // next state
   logic push; // word accepted on the filling side
   logic pop; // word taken on the draining side

   // ready only while a slot is free, so a stalled drain holds the source back
   assign o_in_ready = st_reg.rdy;
   assign o_out_valid = (st_reg.cnt != 2'd0);
   assign o_out_data = st_reg.ent0;
   assign push = i_in_valid && o_in_ready;
   assign pop = o_out_valid && i_out_ready;

   // shift on pop, then write the new word behind whatever remains
   always_comb begin
      st_next = st_reg;
      if (pop) begin
         st_next.ent0 = st_reg.ent1;
      end
      if (push) begin
         if ((st_reg.cnt == 2'd0) || ((st_reg.cnt == 2'd1) && pop)) begin
            st_next.ent0 = i_in_data;
         end else begin
            st_next.ent1 = i_in_data;
         end
      end
      st_next.cnt = 2'(st_reg.cnt + {1'b0, push} - {1'b0, pop});
      st_next.rdy = (st_next.cnt != 2'd2);
   end

   // state register
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_reg <= BUF_RST;
      end else begin
         st_reg <= st_next;
      end
   end
endmodule : word_buf2

// ==== logic/dual_octal_xcvr.sv ====
// dual octal registered transceiver core, sampled on one system clock
//
// What this block does
// - two halves, each with two 8-bit registers
// - capture on clock rise only while enable low
// - each half-direction has own clock and enable
// - drive stored value only while drive enable low
// - drive enable high leaves destination pins floating
// - b-to-a path mirrors a-to-b path
// - the two direction registers never disturb each other
// - bus-hold variant keeps last level on undriven inputs
`timescale 1ns/10ps
module dual_octal_xcvr import xcvr_pkg::*; #(
   parameter bit BUS_HOLD = 1'b1 // 1: undriven inputs keep their last level
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // direction controls, index = half*2 + dir (dir 0 a-to-b, 1 b-to-a)
   input wire ctrl_s [PATHS-1:0] i_ctrl,
   // stall of storage update, per path
   input wire logic [PATHS-1:0] i_stall,
   // a_side_io pins, per half
   input wire byte_t [HALVES-1:0] i_a_in,
   output byte_t [HALVES-1:0] o_a_out,
   output logic [HALVES-1:0] o_a_oe_n,
   // b_side_io pins, per half
   input wire byte_t [HALVES-1:0] i_b_in,
   output byte_t [HALVES-1:0] o_b_out,
   output logic [HALVES-1:0] o_b_oe_n,
   // capture buffer has room, per path
   output logic [PATHS-1:0] o_cap_ready
);
   // whole state of the core
   typedef struct packed {
      ctrl_s [PATHS-1:0] sync1; // first control stage, read only by sync2
      ctrl_s [PATHS-1:0] sync2; // settled controls
      logic [PATHS-1:0] prev_cp; // last settled clock level, for edges
      byte_t [HALVES-1:0] a1; // first a-side data stage
      byte_t [HALVES-1:0] a2; // settled a-side data
      byte_t [HALVES-1:0] b1; // first b-side data stage
      byte_t [HALVES-1:0] b2; // settled b-side data
      byte_t [PATHS-1:0] stg; // storage registers, one per path
      byte_t [HALVES-1:0] a_out; // a-side pin output level
      byte_t [HALVES-1:0] b_out; // b-side pin output level
      logic [HALVES-1:0] a_oe_n; // a-side pin enable, low drives
      logic [HALVES-1:0] b_oe_n; // b-side pin enable, low drives
   } core_s;

   localparam core_s CORE_RST = '{
      sync1: {PATHS{CTRL_IDLE}}, sync2: {PATHS{CTRL_IDLE}}, prev_cp: '0,
      a1: '0, a2: '0, b1: '0, b2: '0, stg: {PATHS{DATA_RST}},
      a_out: '0, b_out: '0, a_oe_n: '1, b_oe_n: '1};

   logic rst_meta_n; // reset release, first stage
   logic rst_sync_n; // reset release, used by the whole design
   core_s st_reg; // registered state
   core_s st_next; // next state
   logic [PATHS-1:0] push; // capture event per path
   byte_t [PATHS-1:0] push_data; // word captured per path
   logic [PATHS-1:0] buf_valid; // buffered word waiting per path
   byte_t [PATHS-1:0] buf_data; // oldest buffered word per path
   logic [PATHS-1:0] pop; // storage register loads this cycle

   // reset asserts at once but releases through two flops
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_meta_n <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_sync_n <= rst_meta_n;
      end
   end

   // capture events: settled clock rising with settled enable low
   always_comb begin
      for (int h = 0; h < HALVES; h++) begin
         push_data[path_idx(h, DIR_AB)] = st_reg.a2[h];
         push_data[path_idx(h, DIR_BA)] = st_reg.b2[h];
      end
      for (int p = 0; p < PATHS; p++) begin
         push[p] = st_reg.sync2[p].cp && !st_reg.prev_cp[p]
                   && !st_reg.sync2[p].ce_n;
      end
   end

   // each path owns its own buffer and storage register
   for (genvar g = 0; g < PATHS; g++) begin : g_path
      word_buf2 #(.W(BYTE_W)) i_word_buf2 (
         .i_clk(i_clk),
         .i_rst_n(rst_sync_n),
         .i_in_valid(push[g]),
         .o_in_ready(o_cap_ready[g]),
         .i_in_data(push_data[g]),
         .o_out_valid(buf_valid[g]),
         .i_out_ready(!i_stall[g]),
         .o_out_data(buf_data[g])
      );
      assign pop[g] = buf_valid[g] && !i_stall[g];
   end

   // next state: synchronise pins, load storage, form pin outputs
   always_comb begin
      st_next = st_reg;
      st_next.sync1 = i_ctrl;
      st_next.sync2 = st_reg.sync1;
      st_next.a1 = i_a_in;
      st_next.a2 = st_reg.a1;
      st_next.b1 = i_b_in;
      st_next.b2 = st_reg.b1;
      for (int p = 0; p < PATHS; p++) begin
         st_next.prev_cp[p] = st_reg.sync2[p].cp;
         // only this path's own register changes; otherwise it holds
         if (pop[p]) begin
            st_next.stg[p] = buf_data[p];
         end
      end
      for (int h = 0; h < HALVES; h++) begin
         // b side follows the a-to-b register and its drive enable
         st_next.b_oe_n[h] = st_reg.sync2[path_idx(h, DIR_AB)].oe_n;
         if (!st_reg.sync2[path_idx(h, DIR_AB)].oe_n) begin
            st_next.b_out[h] = st_reg.stg[path_idx(h, DIR_AB)];
         end else begin
            // keeper level only; enable stays high so the pin floats
            st_next.b_out[h] = BUS_HOLD ? st_reg.b2[h] : DATA_RST;
         end
         // a side mirrors it with the b-to-a register
         st_next.a_oe_n[h] = st_reg.sync2[path_idx(h, DIR_BA)].oe_n;
         if (!st_reg.sync2[path_idx(h, DIR_BA)].oe_n) begin
            st_next.a_out[h] = st_reg.stg[path_idx(h, DIR_BA)];
         end else begin
            st_next.a_out[h] = BUS_HOLD ? st_reg.a2[h] : DATA_RST;
         end
      end
   end

   // state register; reset clears storage and floats every pin
   always_ff @(posedge i_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         st_reg <= CORE_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // pin outputs straight from the state flops
   assign o_a_out = st_reg.a_out;
   assign o_a_oe_n = st_reg.a_oe_n;
   assign o_b_out = st_reg.b_out;
   assign o_b_oe_n = st_reg.b_oe_n;

   // checks that span paths and cycles
   for (genvar g = 0; g < PATHS; g++) begin : g_chk
      property p_no_overflow;
         @(posedge i_clk) disable iff (!rst_sync_n) push[g] |-> o_cap_ready[g];
      endproperty
      a_no_overflow: assert property (p_no_overflow)
         else $error("capture arrived with buffer full");
      property p_capture;
         @(posedge i_clk) disable iff (!rst_sync_n)
            (push[g] && !buf_valid[g] && !i_stall[g]) ##1 !i_stall[g]
            |-> ##1 st_reg.stg[g] == $past(push_data[g], 2);
      endproperty
      a_capture: assert property (p_capture)
         else $error("captured word did not reach storage in two cycles");
      property p_own_edge;
         @(posedge i_clk) disable iff (!rst_sync_n)
            push[g] |-> $rose(st_reg.sync2[g].cp) && !st_reg.sync2[g].ce_n;
      endproperty
      a_own_edge: assert property (p_own_edge)
         else $error("capture without own clock edge and enable");
      property p_hold;
         @(posedge i_clk) disable iff (!rst_sync_n) !pop[g] |=> $stable(st_reg.stg[g]);
      endproperty
      a_hold: assert property (p_hold)
         else $error("storage changed without its own load");
   end

   for (genvar h = 0; h < HALVES; h++) begin : g_pin
      property p_drive_b;
         @(posedge i_clk) disable iff (!rst_sync_n)
            !st_reg.sync2[2*h].oe_n
            |=> !o_b_oe_n[h] && o_b_out[h] == $past(st_reg.stg[2*h]);
      endproperty
      a_drive_b: assert property (p_drive_b)
         else $error("b side not driven with stored word");
      property p_float_b;
         @(posedge i_clk) disable iff (!rst_sync_n)
            st_reg.sync2[2*h].oe_n |=> o_b_oe_n[h];
      endproperty
      a_float_b: assert property (p_float_b)
         else $error("b side driven while disabled");
      property p_drive_a;
         @(posedge i_clk) disable iff (!rst_sync_n)
            !st_reg.sync2[2*h+1].oe_n
            |=> !o_a_oe_n[h] && o_a_out[h] == $past(st_reg.stg[2*h+1]);
      endproperty
      a_drive_a: assert property (p_drive_a)
         else $error("a side not driven with stored word");
      property p_keep_a;
         @(posedge i_clk) disable iff (!rst_sync_n)
            (BUS_HOLD && st_reg.sync2[2*h+1].oe_n) |=> o_a_out[h] == $past(st_reg.a2[h]);
      endproperty
      a_keep_a: assert property (p_keep_a)
         else $error("keeper level does not follow last a-side level");
   end

   property p_power_up;
      @(posedge i_clk) disable iff (!rst_sync_n)
         $rose(rst_sync_n) |-> (&o_a_oe_n) && (&o_b_oe_n) && st_reg.stg == '0;
   endproperty
   a_power_up: assert property (p_power_up)
      else $error("not cleared and floating after reset");

   // main scenarios
   c_stalled_capture: cover property (@(posedge i_clk) disable iff (!rst_sync_n)
      push[0] && i_stall[0]);
   c_drive_b: cover property (@(posedge i_clk) disable iff (!rst_sync_n)
      pop[0] ##[1:8] !o_b_oe_n[0]);
   c_drive_a: cover property (@(posedge i_clk) disable iff (!rst_sync_n)
      pop[3] ##[1:8] !o_a_oe_n[1]);
   c_full: cover property (@(posedge i_clk) disable iff (!rst_sync_n) !o_cap_ready[0]);
endmodule : dual_octal_xcvr

// ==== verification/side_agent.sv ====
// bus agents on one side of the transceiver, resolving each shared pin with the device
`timescale 1ns/10ps
module side_agent import xcvr_pkg::*; (
   // agent drive request and value, per half
   input wire logic [HALVES-1:0] i_drv,
   input wire byte_t [HALVES-1:0] i_val,
   // device side of the same pins
   input wire byte_t [HALVES-1:0] i_dev_out,
   input wire logic [HALVES-1:0] i_dev_oe_n,
   // resolved pin level fed back into the device
   output byte_t [HALVES-1:0] o_pin
);
   // one resolver per half; a fight gives a wrong level, never a kind one
   always_comb begin
      for (int h = 0; h < HALVES; h++) begin
         if (!i_dev_oe_n[h] && i_drv[h]) begin
            o_pin[h] = ~i_val[h];
         end else if (!i_dev_oe_n[h]) begin
            o_pin[h] = i_dev_out[h];
         end else if (i_drv[h]) begin
            o_pin[h] = i_val[h];
         end else begin
            o_pin[h] = i_dev_out[h];
         end
      end
   end
endmodule : side_agent

// ==== verification/dual_octal_xcvr_bench.sv ====
// self-checking bench for the dual octal registered transceiver
`timescale 1ns/10ps
module dual_octal_xcvr_bench import xcvr_pkg::*;;
   localparam int LIMIT = 3000; // cycle ceiling, tests need well under 1000
   localparam byte_t PAT [PATHS] = '{8'ha5, 8'h3c, 8'hc3, 8'h81}; // one word per path
   logic clk;
   logic rst_n;
   ctrl_s [PATHS-1:0] ctrl;
   logic [PATHS-1:0] stall;
   logic [PATHS-1:0] cap_ready;
   logic [HALVES-1:0] a_drv, b_drv, a_oe_n, b_oe_n;
   byte_t [HALVES-1:0] a_val, b_val, a_in, b_in, a_out, b_out;
   int fail_count = 0;
   int total_checks = 0;
   int cycles = 0;

   dual_octal_xcvr #(.BUS_HOLD(1'b1)) i_dual_octal_xcvr (.i_clk(clk), .i_rst_n(rst_n),
      .i_ctrl(ctrl), .i_stall(stall), .i_a_in(a_in), .o_a_out(a_out), .o_a_oe_n(a_oe_n),
      .i_b_in(b_in), .o_b_out(b_out), .o_b_oe_n(b_oe_n), .o_cap_ready(cap_ready));
   side_agent i_side_agent_a (.i_drv(a_drv), .i_val(a_val), .i_dev_out(a_out),
      .i_dev_oe_n(a_oe_n), .o_pin(a_in));
   side_agent i_side_agent_b (.i_drv(b_drv), .i_val(b_val), .i_dev_out(b_out),
      .i_dev_oe_n(b_oe_n), .o_pin(b_in));

   // free-running system clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // hang guard: a run past the ceiling counts as a mismatch
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         fail_count++;
         wrap_up();
      end
   end

   task automatic chk_word(input byte_t got, input byte_t exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_word

   task automatic chk_flags(input logic [PATHS-1:0] got, input logic [PATHS-1:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_flags

   // sample a little after the edge so registered outputs have landed
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : settle

   // source agent drives the word, then one capture clock pulse, 3 cycles high and low
   task automatic pulse(input int p, input byte_t d, input logic ce);
      @(posedge clk);
      if (p % 2 == DIR_AB) begin
         a_drv[p/2] <= 1'b1;
         a_val[p/2] <= d;
      end else begin
         b_drv[p/2] <= 1'b1;
         b_val[p/2] <= d;
      end
      ctrl[p].ce_n <= ce;
      repeat (3) @(posedge clk);
      ctrl[p].cp <= 1'b1;
      repeat (3) @(posedge clk);
      ctrl[p].cp <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : pulse

   // open the destination side, compare, then close it again
   task automatic look(input int p, input byte_t exp);
      @(posedge clk);
      if (p % 2 == DIR_AB) b_drv[p/2] <= 1'b0;
      else a_drv[p/2] <= 1'b0;
      ctrl[p].oe_n <= 1'b0;
      settle(6);
      if (p % 2 == DIR_AB) begin
         chk_word(b_out[p/2], exp);
         chk_flags(4'(b_oe_n[p/2]), 4'h0);
      end else begin
         chk_word(a_out[p/2], exp);
         chk_flags(4'(a_oe_n[p/2]), 4'h0);
      end
      @(posedge clk);
      ctrl[p].oe_n <= 1'b1;
      settle(4);
      chk_flags({b_oe_n, a_oe_n}, 4'hf);
   endtask : look

   task automatic t_reset();
      chk_flags({b_oe_n, a_oe_n}, 4'hf);
      chk_flags(cap_ready, 4'hf);
      look(3, DATA_RST);
      $display("test reset done");
   endtask : t_reset

   // every path in turn, then its source released to see the kept level
   task automatic t_paths();
      for (int p = 0; p < PATHS; p++) begin
         pulse(p, PAT[p], 1'b0);
         look(p, PAT[p]);
         @(posedge clk);
         if (p % 2 == DIR_AB) a_drv[p/2] <= 1'b0;
         else b_drv[p/2] <= 1'b0;
         settle(4);
         chk_word((p % 2 == DIR_AB) ? a_out[p/2] : b_out[p/2], PAT[p]);
      end
      $display("test paths done");
   endtask : t_paths

   task automatic t_ce_off();
      pulse(2, 8'h77, 1'b1);
      look(2, PAT[2]);
      $display("test enable off done");
   endtask : t_ce_off

   // both directions of both halves driven at once, agents all released
   task automatic t_keep();
      @(posedge clk);
      a_drv <= '0;
      b_drv <= '0;
      for (int p = 0; p < PATHS; p++) ctrl[p].oe_n <= 1'b0;
      settle(6);
      for (int h = 0; h < HALVES; h++) begin
         chk_word(b_out[h], PAT[2*h]);
         chk_word(a_out[h], PAT[2*h+1]);
      end
      @(posedge clk);
      for (int p = 0; p < PATHS; p++) ctrl[p].oe_n <= 1'b1;
      settle(4);
      $display("test independence done");
   endtask : t_keep

   // two words wait in a stalled buffer, which then refuses; the last one wins
   task automatic t_stall();
      @(posedge clk);
      stall <= 4'h1;
      pulse(0, 8'h12, 1'b0);
      pulse(0, 8'h34, 1'b0);
      #1;
      chk_flags(cap_ready, 4'he);
      look(0, PAT[0]);
      @(posedge clk);
      stall <= 4'h0;
      look(0, 8'h34);
      chk_flags(cap_ready, 4'hf);
      $display("test stall done");
   endtask : t_stall

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : wrap_up

   // reset for 4 cycles, then the scenarios in order
   initial begin
      for (int p = 0; p < PATHS; p++) ctrl[p] = CTRL_IDLE;
      stall = '0;
      a_drv = '1;
      b_drv = '1;
      a_val = '0;
      b_val = '0;
      rst_n = 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      settle(4);
      t_reset();
      t_paths();
      t_ce_off();
      t_keep();
      t_stall();
      wrap_up();
   end
endmodule : dual_octal_xcvr_bench
